//--- logic/pcrg_pkg.sv
// constants for the express capability register block
package pcrg_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CAP_HEADER = 8'h40;
	localparam logic [7:0] OFS_DEV_CAPS = 8'h44;

	// ----------------------------------------------------------------
	// capability header fields
	// ----------------------------------------------------------------
	localparam int HDR_ID_LSB = 0;
	localparam int HDR_ID_MSB = 7;
	localparam int HDR_LINK_LSB = 8;
	localparam int HDR_LINK_MSB = 15;
	localparam int HDR_REV_LSB = 16;
	localparam int HDR_REV_MSB = 19;
	localparam int HDR_TYPE_LSB = 20;
	localparam int HDR_TYPE_MSB = 23;
	localparam int HDR_SLOT_BIT = 24;
	localparam int HDR_MSGIDX_LSB = 25;
	localparam int HDR_MSGIDX_MSB = 29;
	localparam int HDR_RSVD_LSB = 30;
	localparam int HDR_RSVD_MSB = 31;

	localparam logic [7:0] CAPABILITY_IDENTIFIER = 8'h10;
	localparam logic [7:0] NEXT_LINK_RST = 8'h00;
	localparam logic [3:0] REVISION_RST = 4'h2;
	localparam logic [3:0] TYPE_UPSTREAM = 4'h5;
	localparam logic [3:0] TYPE_DOWNSTREAM = 4'h6;
	localparam logic SLOT_RST = 1'b0;
	localparam logic [4:0] MSG_INDEX_VALUE = 5'h00;

	// ----------------------------------------------------------------
	// device capabilities fields
	// ----------------------------------------------------------------
	localparam int DC_PAYLOAD_LSB = 0;
	localparam int DC_PAYLOAD_MSB = 2;
	localparam int DC_FUNCBITS_LSB = 3;
	localparam int DC_FUNCBITS_MSB = 4;
	localparam int DC_WIDETAG_BIT = 5;
	localparam int DC_LIGHT_LSB = 6;
	localparam int DC_LIGHT_MSB = 8;
	localparam int DC_DEEP_LSB = 9;
	localparam int DC_DEEP_MSB = 11;
	localparam int DC_BUTTON_BIT = 12;
	localparam int DC_ATTN_LAMP_BIT = 13;
	localparam int DC_POWER_LAMP_BIT = 14;

	localparam logic [2:0] PAYLOAD_RST = 3'h4;
	localparam logic [2:0] PAYLOAD_128 = 3'h0;
	localparam logic [2:0] PAYLOAD_LAST_VALID = 3'h5;
	localparam logic [1:0] FUNCBITS_VALUE = 2'h0;
	localparam logic WIDETAG_RST = 1'b1;
	localparam logic [2:0] LIGHT_SLEEP_VALUE = 3'h0;
	localparam logic [2:0] DEEP_SLEEP_VALUE = 3'h0;

	// ----------------------------------------------------------------
	// local control and status fields
	// ----------------------------------------------------------------
	localparam int CTRL_UNLOCK_BIT = 0;
	localparam logic CTRL_UNLOCK_RST = 1'b0;
	localparam int STAT_UPSTREAM_BIT = 0;
	localparam int STAT_UNLOCKED_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;

	// ----------------------------------------------------------------
	// register select and bus handshake state
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_CTRL = 5'b00010,
		SEL_STATUS = 5'b00100,
		SEL_HEADER = 5'b01000,
		SEL_DEVCAP = 5'b10000
	} pcrg_sel_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ANSWER = 2'b10
	} pcrg_state_e;

endpackage

//--- logic/pcrg_payload_norm.sv
// maps the stored payload code onto the code the port logic acts on
`timescale 1ns/1ps

module pcrg_payload_norm (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] code_i,
	output logic [2:0] code_o
);

	// ----------------------------------------------------------------
	// normalisation
	// ----------------------------------------------------------------
	logic [2:0] code_d;
	logic [2:0] code_q;

	// reserved codes fall back to the smallest payload
	always_comb begin
		if (code_i > pcrg_pkg::PAYLOAD_LAST_VALID) begin
			code_d = pcrg_pkg::PAYLOAD_128;
		end else begin
			code_d = code_i;
		end
	end

	// registered so the consumer sees a clean level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_q <= pcrg_pkg::PAYLOAD_RST;
		end else begin
			code_q <= code_d;
		end
	end

	assign code_o = code_q;

endmodule

//--- logic/pcrg_top.sv
// express capability header and device capabilities, wishbone slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps

module pcrg_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic port_upstream_i,
	output logic port_upstream_o,
	output logic slot_present_o,
	output logic [2:0] payload_code_o,
	output logic wide_tag_o
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------

	// shared by the read path and the write path
	// misaligned offsets fall out as unmapped, so they end in err
	function automatic pcrg_pkg::pcrg_sel_e decode_sel(input logic [7:0] adr);
		pcrg_pkg::pcrg_sel_e s;
		s = pcrg_pkg::SEL_NONE;
		if (adr[1:0] == 2'h0) begin
			if (adr == pcrg_pkg::OFS_CTRL) begin
				s = pcrg_pkg::SEL_CTRL;
			end else if (adr == pcrg_pkg::OFS_STATUS) begin
				s = pcrg_pkg::SEL_STATUS;
			end else if (adr == pcrg_pkg::OFS_CAP_HEADER) begin
				s = pcrg_pkg::SEL_HEADER;
			end else if (adr == pcrg_pkg::OFS_DEV_CAPS) begin
				s = pcrg_pkg::SEL_DEVCAP;
			end
		end
		return s;
	endfunction

	// byte-lane merge for writable fields
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// bus answer registers
	pcrg_pkg::pcrg_state_e state_q;
	pcrg_pkg::pcrg_state_e state_d;
	logic ack_q;
	logic ack_d;
	logic err_q;
	logic err_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// port role and local control state
	logic upstream_q;
	logic upstream_d;
	logic unlock_q;
	logic unlock_d;
	logic refused_q;
	logic refused_d;

	// capability fields software may rewrite while unlocked
	logic [7:0] next_link_q;
	logic [7:0] next_link_d;
	logic [3:0] revision_q;
	logic [3:0] revision_d;
	logic slot_q;
	logic slot_d;
	logic [2:0] payload_q;
	logic [2:0] payload_d;
	logic wide_tag_q;
	logic wide_tag_d;

	// combinational helpers
	logic req;
	logic wr_commit;
	logic [31:0] merged;
	logic [31:0] header_view;
	logic [31:0] devcap_view;
	logic [31:0] status_view;
	pcrg_pkg::pcrg_sel_e sel;
	logic [2:0] payload_norm;

	// ----------------------------------------------------------------
	// register views
	// ----------------------------------------------------------------
	// reserved payload codes read back exactly as written; only the port
	// logic sees them folded, so software can still tell what it stored

	// capability header as software sees it
	// type follows the strap caught in reset, never the live pin
	always_comb begin
		header_view = 32'h0000_0000; // reserved top bits stay zero
		header_view[pcrg_pkg::HDR_ID_MSB:pcrg_pkg::HDR_ID_LSB] =
			pcrg_pkg::CAPABILITY_IDENTIFIER;
		header_view[pcrg_pkg::HDR_LINK_MSB:pcrg_pkg::HDR_LINK_LSB] = next_link_q;
		header_view[pcrg_pkg::HDR_REV_MSB:pcrg_pkg::HDR_REV_LSB] = revision_q;
		if (upstream_q) begin
			header_view[pcrg_pkg::HDR_TYPE_MSB:pcrg_pkg::HDR_TYPE_LSB] =
				pcrg_pkg::TYPE_UPSTREAM;
		end else begin
			header_view[pcrg_pkg::HDR_TYPE_MSB:pcrg_pkg::HDR_TYPE_LSB] =
				pcrg_pkg::TYPE_DOWNSTREAM;
		end
		header_view[pcrg_pkg::HDR_SLOT_BIT] = slot_q;
		header_view[pcrg_pkg::HDR_MSGIDX_MSB:pcrg_pkg::HDR_MSGIDX_LSB] =
			pcrg_pkg::MSG_INDEX_VALUE; // single vector only
	end

	// lower device capabilities; bits 15 and up belong elsewhere
	always_comb begin
		devcap_view = 32'h0000_0000;
		devcap_view[pcrg_pkg::DC_PAYLOAD_MSB:pcrg_pkg::DC_PAYLOAD_LSB] = payload_q;
		devcap_view[pcrg_pkg::DC_FUNCBITS_MSB:pcrg_pkg::DC_FUNCBITS_LSB] =
			pcrg_pkg::FUNCBITS_VALUE;
		devcap_view[pcrg_pkg::DC_WIDETAG_BIT] = wide_tag_q;
		devcap_view[pcrg_pkg::DC_LIGHT_MSB:pcrg_pkg::DC_LIGHT_LSB] =
			pcrg_pkg::LIGHT_SLEEP_VALUE; // endpoint-only field
		devcap_view[pcrg_pkg::DC_DEEP_MSB:pcrg_pkg::DC_DEEP_LSB] =
			pcrg_pkg::DEEP_SLEEP_VALUE; // endpoint-only field
		devcap_view[pcrg_pkg::DC_BUTTON_BIT] = 1'b0;
		devcap_view[pcrg_pkg::DC_ATTN_LAMP_BIT] = 1'b0;
		devcap_view[pcrg_pkg::DC_POWER_LAMP_BIT] = 1'b0;
	end

	// local status word
	always_comb begin
		status_view = 32'h0000_0000;
		status_view[pcrg_pkg::STAT_UPSTREAM_BIT] = upstream_q;
		status_view[pcrg_pkg::STAT_UNLOCKED_BIT] = unlock_q;
		status_view[pcrg_pkg::STAT_REFUSED_BIT] = refused_q;
	end

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// every access takes two cycles: taken on one edge, answered on the next;
	// a strobe still high in the answer cycle is ignored, which costs a
	// cycle between accesses but never answers one request twice

	// one answer per request, a cycle after it is taken; the answer state forces ack to drop
	always_comb begin
		req = wb_cyc_i && wb_stb_i;
		sel = decode_sel(wb_adr_i);
		state_d = state_q;
		ack_d = 1'b0;
		err_d = 1'b0;
		rdata_d = rdata_q;
		wr_commit = 1'b0;
		unique case (state_q)
			pcrg_pkg::ST_IDLE: begin
				if (req) begin
					state_d = pcrg_pkg::ST_ANSWER;
					ack_d = (sel != pcrg_pkg::SEL_NONE);
					// err answers carry zero data so no stale word leaks out
					err_d = (sel == pcrg_pkg::SEL_NONE);
					wr_commit = wb_we_i && (sel != pcrg_pkg::SEL_NONE);
					unique case (sel)
						pcrg_pkg::SEL_CTRL: rdata_d = {31'h0000_0000, unlock_q};
						pcrg_pkg::SEL_STATUS: rdata_d = status_view;
						pcrg_pkg::SEL_HEADER: rdata_d = header_view;
						pcrg_pkg::SEL_DEVCAP: rdata_d = devcap_view;
						default: rdata_d = 32'h0000_0000;
					endcase
				end
			end
			pcrg_pkg::ST_ANSWER: begin
				// wait one cycle so back-to-back strobes are not answered twice
				state_d = pcrg_pkg::ST_IDLE;
			end
			default: begin
				state_d = pcrg_pkg::ST_IDLE;
			end
		endcase
	end

	// answer registers; reset clears ack and err so no stray pulse follows it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= pcrg_pkg::ST_IDLE;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			ack_q <= ack_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// writable fields
	// ----------------------------------------------------------------
	// a refused write is still acked so software never stalls; the sticky
	// status bit is the only trace it leaves

	// locked fields only change while the unlock bit is set
	always_comb begin
		merged = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
		unlock_d = unlock_q;
		next_link_d = next_link_q;
		revision_d = revision_q;
		slot_d = slot_q;
		payload_d = payload_q;
		wide_tag_d = wide_tag_q;
		refused_d = refused_q;
		if (wr_commit) begin
			unique case (sel)
				pcrg_pkg::SEL_CTRL: begin
					// only bit 0 of lane 0 has storage behind it
					if (wb_sel_i[0]) begin
						unlock_d = merged[pcrg_pkg::CTRL_UNLOCK_BIT];
					end
				end
				pcrg_pkg::SEL_STATUS: begin
					if (wb_sel_i[0] && merged[pcrg_pkg::STAT_REFUSED_BIT]) begin
						refused_d = 1'b0;
					end
				end
				pcrg_pkg::SEL_HEADER: begin
					// id, type, index and top bits ignore writes
					if (!unlock_q) begin
						refused_d = 1'b1;
					end else begin
						if (wb_sel_i[1]) begin
							next_link_d = merged[pcrg_pkg::HDR_LINK_MSB:pcrg_pkg::HDR_LINK_LSB];
						end
						if (wb_sel_i[2]) begin
							revision_d = merged[pcrg_pkg::HDR_REV_MSB:pcrg_pkg::HDR_REV_LSB];
						end
						if (wb_sel_i[3]) begin
							// an upstream port never claims a slot
							slot_d = merged[pcrg_pkg::HDR_SLOT_BIT] && !upstream_q;
						end
					end
				end
				pcrg_pkg::SEL_DEVCAP: begin
					if (!unlock_q) begin
						refused_d = 1'b1;
					end else if (wb_sel_i[0]) begin
						// payload code and wide tag share lane 0, so they move together
						payload_d = merged[pcrg_pkg::DC_PAYLOAD_MSB:pcrg_pkg::DC_PAYLOAD_LSB];
						wide_tag_d = merged[pcrg_pkg::DC_WIDETAG_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// port role is caught while reset is held, so it cannot glitch later
	always_comb begin
		upstream_d = upstream_q;
		if (rst_i) begin
			upstream_d = port_upstream_i;
		end
	end

	// no reset branch: the capture above is what sets this flop in reset
	always_ff @(posedge clk_i) begin
		upstream_q <= upstream_d;
	end

	// reset values of the rewritable fields; the unlock bit starts clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unlock_q <= pcrg_pkg::CTRL_UNLOCK_RST;
			refused_q <= 1'b0;
			next_link_q <= pcrg_pkg::NEXT_LINK_RST;
			revision_q <= pcrg_pkg::REVISION_RST;
			slot_q <= pcrg_pkg::SLOT_RST;
			payload_q <= pcrg_pkg::PAYLOAD_RST;
			wide_tag_q <= pcrg_pkg::WIDETAG_RST;
		end else begin
			unlock_q <= unlock_d;
			refused_q <= refused_d;
			next_link_q <= next_link_d;
			revision_q <= revision_d;
			slot_q <= slot_d;
			payload_q <= payload_d;
			wide_tag_q <= wide_tag_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs to the port logic
	// ----------------------------------------------------------------

	// the port logic sees reserved payload codes already folded
	// and one cycle after the register changes, as the fold is registered
	pcrg_payload_norm u_norm (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.code_i(payload_q),
		.code_o(payload_norm)
	);

	// every pin below is a flop output with no logic in between
	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign port_upstream_o = upstream_q;
	assign slot_present_o = slot_q;
	assign payload_code_o = payload_norm;
	assign wide_tag_o = wide_tag_q;

endmodule

//--- sim/pcrg_top_assertions.sv
// concurrent checks on the capability register block ports
`timescale 1ns/1ps
module pcrg_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic port_upstream_i,
	input wire logic port_upstream_o,
	input wire logic slot_present_o,
	input wire logic [2:0] payload_code_o,
	input wire logic wide_tag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// read answers, the master holds address and direction until ack
	// ----------------------------------------------------------------
	sequence s_rd_hdr;
		wb_ack_o && !wb_we_i && wb_adr_i == pcrg_pkg::OFS_CAP_HEADER;
	endsequence
	sequence s_rd_dc;
		wb_ack_o && !wb_we_i && wb_adr_i == pcrg_pkg::OFS_DEV_CAPS;
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_err_pulse;
		wb_err_o |=> !wb_err_o && !wb_ack_o;
	endproperty
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	property p_hdr_id;
		s_rd_hdr |-> wb_dat_o[7:0] == 8'h10;
	endproperty
	property p_hdr_type;
		s_rd_hdr |-> wb_dat_o[23:20] == (port_upstream_o ? 4'h5 : 4'h6);
	endproperty
	property p_hdr_zero;
		s_rd_hdr |-> wb_dat_o[31:25] == 7'h00 && wb_dat_o[24] == slot_present_o;
	endproperty
	property p_up_slot;
		port_upstream_o |-> !slot_present_o;
	endproperty
	property p_dc_zero;
		s_rd_dc |-> wb_dat_o[14:6] == 9'h000 && wb_dat_o[4:3] == 2'h0;
	endproperty
	property p_dc_follow;
		s_rd_dc |-> wide_tag_o == wb_dat_o[5]
			&& payload_code_o == (wb_dat_o[2:0] > 3'h5 ? 3'h0 : wb_dat_o[2:0]);
	endproperty
	property p_pay_legal;
		payload_code_o <= 3'h5;
	endproperty
	property p_reset_vals;
		$fell(rst_i) |-> payload_code_o == 3'h4 && wide_tag_o && !slot_present_o;
	endproperty

	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_err_pulse: assert property (p_err_pulse) else $error("err longer than one cycle");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_hdr_id: assert property (p_hdr_id) else $error("bad identifier");
	a_hdr_type: assert property (p_hdr_type) else $error("bad port type");
	a_hdr_zero: assert property (p_hdr_zero) else $error("bad header top");
	a_up_slot: assert property (p_up_slot) else $error("slot set upstream");
	a_dc_zero: assert property (p_dc_zero) else $error("fixed caps bits set");
	a_dc_follow: assert property (p_dc_follow) else $error("caps outputs differ");
	a_pay_legal: assert property (p_pay_legal) else $error("reserved payload out");
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
endmodule

//--- sim/pcrg_top_tb.sv
// self-checking bench for the capability register block
`timescale 1ns/1ps
module pcrg_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic port_upstream_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic wb_err_o;
	logic port_upstream_o;
	logic slot_present_o;
	logic [2:0] payload_code_o;
	logic wide_tag_o;
	logic [31:0] rd;
	logic er;
	logic [2:0] p;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	// 100 ns period
	always #50 clk_i = ~clk_i;

	pcrg_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port_upstream_i,
		.port_upstream_o, .slot_present_o, .payload_code_o, .wide_tag_o);

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// hang guard, the whole run needs about 150 cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// bus and port access
	// ----------------------------------------------------------------
	// entered just after a rising edge; ack or err and read data are taken at the
	// rising edge that samples either one high, and only then is the request dropped
	task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
			errors++;
			close_out();
		end
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// full word and the err flag are both compared, so no bit hides
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 4'hF, 32'h0000_0000);
		chk(rd, exp);
		chk({31'h0000_0000, er}, 32'h0000_0000);
	endtask

	// packs upstream, slot, payload and tag outputs
	task automatic pchk(input logic [31:0] exp);
		@(negedge clk_i);
		chk({26'h0, port_upstream_o, slot_present_o, payload_code_o, wide_tag_o}, exp);
		@(posedge clk_i);
	endtask

	task automatic do_reset(input logic up);
		rst_i <= 1'b1;
		port_upstream_i <= up;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		do_reset(1'b0);
		pchk(32'h0000_0009);
		rdc(8'h40, 32'h0062_0010);
		rdc(8'h44, 32'h0000_0024);
		// locked fields are acked but keep their values
		xfer(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
		rdc(8'h40, 32'h0062_0010);
		xfer(1'b1, 8'h44, 4'hF, 32'h0000_0000);
		rdc(8'h44, 32'h0000_0024);
		rdc(8'h04, 32'h0000_0004);
		xfer(1'b1, 8'h04, 4'h1, 32'h0000_0004);
		rdc(8'h04, 32'h0000_0000);
		// unlocked: only writable fields take the ones
		xfer(1'b1, 8'h00, 4'h1, 32'h0000_0001);
		rdc(8'h00, 32'h0000_0001);
		rdc(8'h04, 32'h0000_0002);
		xfer(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
		rdc(8'h40, 32'h016F_FF10);
		pchk(32'h0000_0019);
		xfer(1'b1, 8'h40, 4'h6, 32'h0003_3A00);
		rdc(8'h40, 32'h0163_3A10);
		// every payload code, reserved ones must act as the smallest
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, 8'h44, 4'hF, 32'hFFFF_FFF8 | 32'(c));
			rdc(8'h44, 32'h0000_0020 | 32'(c));
			p = (c > 5) ? 3'h0 : 3'(c);
			pchk({26'h0, 2'b01, p, 1'b1});
		end
		xfer(1'b1, 8'h44, 4'h1, 32'h0000_0004);
		rdc(8'h44, 32'h0000_0004);
		pchk(32'h0000_0018);
		// unmapped and misaligned places answer with err and zero data
		xfer(1'b0, 8'h80, 4'hF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		xfer(1'b1, 8'h42, 4'hF, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h0000_0001);
		rdc(8'h40, 32'h0163_3A10);
		// second reset as an upstream port
		do_reset(1'b1);
		pchk(32'h0000_0029);
		rdc(8'h40, 32'h0052_0010);
		xfer(1'b1, 8'h00, 4'h1, 32'h0000_0001);
		xfer(1'b1, 8'h40, 4'h8, 32'hFF00_0000);
		rdc(8'h40, 32'h0052_0010);
		pchk(32'h0000_0029);
		rdc(8'h04, 32'h0000_0003);
		close_out();
	end
endmodule

bind pcrg_top pcrg_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port_upstream_i,
	.port_upstream_o, .slot_present_o, .payload_code_o, .wide_tag_o);
